/* File: ssrx_pkg.sv */
/*
 * Constants of the synchronous slave serial receiver: register indices,
 * field positions, reset values and the wake vector.
 * Assumes an 8-bit Avalon-MM slave addressed by register index.
 */
package ssrx_pkg;
    // Register indices; byte address equals the index on the 8-bit bus
    localparam logic [7:0] IDX_GLOBAL_INTERRUPT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
    localparam logic [7:0] IDX_TRANSMIT_HOLDING = 8'h19;
    localparam logic [7:0] IDX_RECEIVE_HOLDING = 8'h1A;
    localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
    localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;
    // Field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int RECEIVE_IRQ_BIT = 5;
    localparam int SERIAL_PORT_ENABLE_BIT = 7;
    localparam int NINE_BIT_RECEIVE_SELECT_BIT = 6;
    localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int FRAMING_ERROR_FLAG_BIT = 2;
    localparam int OVERRUN_ERROR_FLAG_BIT = 1;
    localparam int RECEIVED_NINTH_BIT_BIT = 0;
    localparam int CLOCK_SOURCE_SELECT_BIT = 7;
    localparam int SYNC_MODE_BIT = 4;
    localparam int SHIFT_REGISTER_EMPTY_BIT = 1;
    // Writable masks and reset values
    localparam logic [7:0] GLOBAL_INTERRUPT_CONTROL_MASK = 8'hC0;
    localparam logic [7:0] RECEIVE_STATUS_CONTROL_MASK = 8'hF0;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_MASK = 8'hF5;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RESET = 8'h02;
    // Last bit index for 8- and 9-bit words
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    // Interrupt vector taken on wake-up
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
endpackage

/* File: ssrx_top.sv */
/*
 * Synchronous slave serial receiver with its register file.
 * Assumes an external master drives the shift clock and data pins, a core
 * that reports sleep and obeys wake and vector outputs, and an Avalon-MM
 * master that holds requests until waitrequest falls.
 */
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ssrx_top (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [7:0] avs_writedata_i,
    output logic [7:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic shift_clk_pin_i,
    input wire logic data_pin_i,
    input wire logic core_sleep_i,
    output logic irq_o,
    output logic wake_o,
    output logic branch_to_vector_o,
    output logic [12:0] vector_addr_o
);
    logic ack_q;
    logic [7:0] rd_d;
    logic [7:0] rd_q;
    logic wr_en_w;
    logic [1:0] gic_q;
    logic receive_irq_flag_q;
    logic [7:0] pie_q;
    logic [3:0] receive_status_control_q;
    logic overrun_error_flag_q;
    logic received_ninth_bit_q;
    logic [7:0] transmit_holding_q;
    logic [7:0] transmit_status_control_q;
    logic [7:0] baud_divisor_q;
    logic [7:0] receive_holding_q;
    logic clk_meta_q;
    logic clk_sync_q;
    logic clk_prev_q;
    logic dat_meta_q;
    logic dat_sync_q;
    logic sclk_rise_w;
    logic [3:0] bit_cnt_q;
    logic [8:0] shift_q;
    logic [8:0] word_w;
    logic last_w;
    logic rx_en_w;
    logic word_done_w;
    logic receive_irq_flag_clr_w;
    logic continuous_receive_enable_w;
    logic rx9_w;
    logic receive_irq_enable_w;
    logic peripheral_irq_enable_w;
    logic gie_w;

    // Control bits picked from the register file
    assign continuous_receive_enable_w = receive_status_control_q[ssrx_pkg::CONTINUOUS_RECEIVE_ENABLE_BIT - 4];
    assign rx9_w = receive_status_control_q[ssrx_pkg::NINE_BIT_RECEIVE_SELECT_BIT - 4];
    assign receive_irq_enable_w = pie_q[ssrx_pkg::RECEIVE_IRQ_BIT];
    assign peripheral_irq_enable_w = gic_q[ssrx_pkg::PERIPHERAL_IRQ_ENABLE_BIT - 6];
    assign gie_w = gic_q[ssrx_pkg::GLOBAL_IRQ_ENABLE_BIT - 6];

    // One wait cycle per access; a held request is answered again every second cycle
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign wr_en_w = avs_write_i & ack_q;
    assign avs_readdata_o = rd_q;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    // Read mux; unmapped indices and unimplemented bits read zero
    always_comb begin
        rd_d = 8'h00;
        unique case (avs_address_i)
            ssrx_pkg::IDX_GLOBAL_INTERRUPT_CONTROL: rd_d = {gic_q, 6'h00};
            ssrx_pkg::IDX_PERIPHERAL_FLAGS: rd_d = {2'h0, receive_irq_flag_q, 5'h00};
            ssrx_pkg::IDX_RECEIVE_STATUS_CONTROL: rd_d = {receive_status_control_q, 1'b0, 1'b0, overrun_error_flag_q, received_ninth_bit_q};
            ssrx_pkg::IDX_TRANSMIT_HOLDING: rd_d = transmit_holding_q;
            ssrx_pkg::IDX_RECEIVE_HOLDING: rd_d = receive_holding_q;
            ssrx_pkg::IDX_PERIPHERAL_ENABLES: rd_d = pie_q;
            ssrx_pkg::IDX_TRANSMIT_STATUS_CONTROL: rd_d = transmit_status_control_q;
            ssrx_pkg::IDX_BAUD_DIVISOR: rd_d = baud_divisor_q;
            default: rd_d = 8'h00;
        endcase
    end

    // Read data captured in the wait cycle, valid when waitrequest falls
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_q <= 8'h00;
        end else if (avs_read_i & ~ack_q) begin
            rd_q <= rd_d;
        end
    end

    // Plain software registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gic_q <= 2'h0;
            pie_q <= ssrx_pkg::RESET_BYTE;
            receive_status_control_q <= 4'h0;
            transmit_holding_q <= ssrx_pkg::RESET_BYTE;
            transmit_status_control_q <= ssrx_pkg::TRANSMIT_STATUS_CONTROL_RESET;
            baud_divisor_q <= ssrx_pkg::RESET_BYTE;
        end else if (wr_en_w) begin
            unique case (avs_address_i)
                ssrx_pkg::IDX_GLOBAL_INTERRUPT_CONTROL: gic_q <= avs_writedata_i[7:6];
                ssrx_pkg::IDX_RECEIVE_STATUS_CONTROL: receive_status_control_q <= avs_writedata_i[7:4];
                ssrx_pkg::IDX_TRANSMIT_HOLDING: transmit_holding_q <= avs_writedata_i;
                ssrx_pkg::IDX_PERIPHERAL_ENABLES: pie_q <= avs_writedata_i;
                ssrx_pkg::IDX_TRANSMIT_STATUS_CONTROL: begin
                    // Empty flag stays set: no transmit path shifts here
                    transmit_status_control_q <= (avs_writedata_i & ssrx_pkg::TRANSMIT_STATUS_CONTROL_MASK)
                               | ssrx_pkg::TRANSMIT_STATUS_CONTROL_RESET;
                end
                ssrx_pkg::IDX_BAUD_DIVISOR: baud_divisor_q <= avs_writedata_i;
                default: ;
            endcase
        end
    end

    // Two-flop synchronisers for the pins, then an edge history flop
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_meta_q <= 1'b0;
            clk_sync_q <= 1'b0;
            clk_prev_q <= 1'b0;
            dat_meta_q <= 1'b0;
            dat_sync_q <= 1'b0;
        end else begin
            clk_meta_q <= shift_clk_pin_i;
            clk_sync_q <= clk_meta_q;
            clk_prev_q <= clk_sync_q;
            dat_meta_q <= data_pin_i;
            dat_sync_q <= dat_meta_q;
        end
    end

    // Clock comes only from the pin; single-receive and sleep play no part
    assign sclk_rise_w = clk_sync_q & ~clk_prev_q;
    assign rx_en_w = receive_status_control_q[ssrx_pkg::SERIAL_PORT_ENABLE_BIT - 4]
                     & transmit_status_control_q[ssrx_pkg::SYNC_MODE_BIT]
                     & ~transmit_status_control_q[ssrx_pkg::CLOCK_SOURCE_SELECT_BIT]
                     & continuous_receive_enable_w
                     & ~overrun_error_flag_q;
    assign last_w = bit_cnt_q == (rx9_w ? ssrx_pkg::LAST_BIT_9 : ssrx_pkg::LAST_BIT_8);
    assign word_done_w = rx_en_w & sclk_rise_w & last_w;

    // Word with the bit now arriving merged in
    always_comb begin
        word_w = shift_q;
        word_w[bit_cnt_q] = dat_sync_q;
    end

    // Shift register, LSB first, one bit per external clock rise
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt_q <= 4'h0;
            shift_q <= 9'h000;
        end else if (!rx_en_w) begin
            bit_cnt_q <= 4'h0;
        end else if (sclk_rise_w) begin
            shift_q <= word_w;
            bit_cnt_q <= last_w ? 4'h0 : bit_cnt_q + 4'h1;
        end
    end

    // Transfer to holding register unless the receive flag is still set
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            receive_holding_q <= ssrx_pkg::RESET_BYTE;
            received_ninth_bit_q <= 1'b0;
        end else if (word_done_w & ~receive_irq_flag_q) begin
            receive_holding_q <= word_w[7:0];
            received_ninth_bit_q <= rx9_w & word_w[8];
        end
    end

    // Overrun: word lost and reception held until enable is cleared
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            overrun_error_flag_q <= 1'b0;
        end else if (!continuous_receive_enable_w) begin
            overrun_error_flag_q <= 1'b0;
        end else if (word_done_w & receive_irq_flag_q) begin
            overrun_error_flag_q <= 1'b1;
        end
    end

    // Receive flag, write one to clear; a new word wins over the clear
    assign receive_irq_flag_clr_w = wr_en_w & (avs_address_i == ssrx_pkg::IDX_PERIPHERAL_FLAGS)
                        & avs_writedata_i[ssrx_pkg::RECEIVE_IRQ_BIT];
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            receive_irq_flag_q <= 1'b0;
        end else if (word_done_w) begin
            receive_irq_flag_q <= 1'b1;
        end else if (receive_irq_flag_clr_w) begin
            receive_irq_flag_q <= 1'b0;
        end
    end

    // Interrupt, wake and vector outputs
    assign irq_o = receive_irq_flag_q & receive_irq_enable_w;
    assign wake_o = core_sleep_i & receive_irq_flag_q & receive_irq_enable_w & peripheral_irq_enable_w;
    assign branch_to_vector_o = wake_o & gie_w;
    assign vector_addr_o = branch_to_vector_o ? ssrx_pkg::IRQ_VECTOR : 13'h0000;

    sequence s_done;
        word_done_w && !receive_irq_flag_q;
    endsequence

    property p_flag_set;
        @(posedge mclk_i) disable iff (!reset_n_i) s_done |=> receive_irq_flag_q && irq_o == receive_irq_enable_w;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("receive flag not set");

    property p_holding;
        @(posedge mclk_i) disable iff (!reset_n_i) s_done |=> receive_holding_q == $past(word_w[7:0]);
    endproperty
    a_holding: assert property (p_holding) else $error("holding not loaded");

    property p_ninth;
        @(posedge mclk_i) disable iff (!reset_n_i) s_done ##0 rx9_w |=> received_ninth_bit_q == $past(dat_sync_q);
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit wrong");

    property p_disabled;
        @(posedge mclk_i) disable iff (!reset_n_i) !continuous_receive_enable_w |=> bit_cnt_q == 4'h0 && !overrun_error_flag_q;
    endproperty
    a_disabled: assert property (p_disabled) else $error("receiving while disabled");

    property p_err_clear;
        @(posedge mclk_i) disable iff (!reset_n_i) $fell(continuous_receive_enable_w) |=> !overrun_error_flag_q;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error kept after disable");

    property p_master_mode;
        @(posedge mclk_i) disable iff (!reset_n_i)
            transmit_status_control_q[ssrx_pkg::CLOCK_SOURCE_SELECT_BIT] |=> bit_cnt_q == 4'h0;
    endproperty
    a_master_mode: assert property (p_master_mode) else $error("shifting with internal clock");

    property p_wake;
        @(posedge mclk_i) disable iff (!reset_n_i)
            $rose(receive_irq_flag_q) && core_sleep_i && receive_irq_enable_w && peripheral_irq_enable_w |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on receive");

    property p_vector;
        @(posedge mclk_i) disable iff (!reset_n_i)
            wake_o |-> vector_addr_o == (gie_w ? 13'h0004 : 13'h0000);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong wake vector");

    property p_zero_bits;
        @(posedge mclk_i) disable iff (!reset_n_i)
            avs_read_i && !ack_q && avs_address_i == ssrx_pkg::IDX_RECEIVE_STATUS_CONTROL
            |=> avs_readdata_o[3:2] == 2'h0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bits set");

    property p_wait;
        @(posedge mclk_i) disable iff (!reset_n_i)
            (avs_read_i || avs_write_i) && !ack_q |-> avs_waitrequest_o ##1 ack_q;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");

    // Frame steps: a counted rise inside the word, and a word meeting a full flag
    sequence s_bit_taken;
        rx_en_w && sclk_rise_w && !last_w;
    endsequence

    sequence s_overrun;
        word_done_w && receive_irq_flag_q;
    endsequence

    sequence s_clear_only;
        receive_irq_flag_clr_w && !word_done_w;
    endsequence

    sequence s_read_req;
        avs_read_i && !ack_q;
    endsequence

    // Asleep with both enables set; checked across two cycles
    sequence s_wake_ready;
        core_sleep_i && receive_irq_enable_w && peripheral_irq_enable_w;
    endsequence

    // Each counted rise moves the bit counter on by one
    property p_bit_count;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_bit_taken |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1;
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bit counter skipped");

    // The arriving bit lands at the position the counter named
    property p_bit_stored;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_bit_taken |=> shift_q[$past(bit_cnt_q)] == $past(dat_sync_q);
    endproperty
    a_bit_stored: assert property (p_bit_stored) else $error("bit stored in wrong place");

    // A word meeting a full flag is dropped; the unread word survives
    property p_overrun_set;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_overrun |=> overrun_error_flag_q && receive_holding_q == $past(receive_holding_q);
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("overrun not raised");

    // Reception stays stopped while the overrun is pending
    property p_overrun_stops;
        @(posedge mclk_i) disable iff (!reset_n_i)
            overrun_error_flag_q && continuous_receive_enable_w |=> bit_cnt_q == 4'h0 && overrun_error_flag_q;
    endproperty
    a_overrun_stops: assert property (p_overrun_stops) else $error("receiving past an overrun");

    // Write one clears the flag when no word closes in the same cycle
    property p_flag_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_clear_only |=> !receive_irq_flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    // A closing word beats a clear in the same cycle, so no event is lost
    property p_set_wins;
        @(posedge mclk_i) disable iff (!reset_n_i)
            word_done_w && receive_irq_flag_clr_w |=> receive_irq_flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new word");

    // Only a write of one lowers the flag; reading the data leaves it
    property p_flag_holds;
        @(posedge mclk_i) disable iff (!reset_n_i)
            receive_irq_flag_q && !receive_irq_flag_clr_w |=> receive_irq_flag_q;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag lost");

    // Holding register read returns the stored word
    property p_holding_read;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_read_req ##0 (avs_address_i == ssrx_pkg::IDX_RECEIVE_HOLDING)
            |=> avs_readdata_o == $past(receive_holding_q);
    endproperty
    a_holding_read: assert property (p_holding_read) else $error("holding read wrong");

    // Flag register shows nothing but the receive flag
    property p_flag_read;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_read_req ##0 (avs_address_i == ssrx_pkg::IDX_PERIPHERAL_FLAGS)
            |=> avs_readdata_o[7:6] == 2'h0 && avs_readdata_o[4:0] == 5'h00;
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag register bits set");

    // Sleep alone never stops a word from landing
    property p_sleep_rx;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_done ##0 core_sleep_i |=> receive_irq_flag_q && receive_holding_q == $past(word_w[7:0]);
    endproperty
    a_sleep_rx: assert property (p_sleep_rx) else $error("word lost in sleep");

    // Completion in sleep with both enables held wakes the core next cycle
    property p_wake_next;
        @(posedge mclk_i) disable iff (!reset_n_i)
            s_done ##0 s_wake_ready ##1 s_wake_ready |-> wake_o;
    endproperty
    a_wake_next: assert property (p_wake_next) else $error("no wake after completion");

    // With continuous receive off no word completes, whatever single-receive says
    property p_single_ignored;
        @(posedge mclk_i) disable iff (!reset_n_i)
            !continuous_receive_enable_w |=> !$rose(receive_irq_flag_q);
    endproperty
    a_single_ignored: assert property (p_single_ignored) else $error("word taken without enable");

endmodule
`default_nettype wire

/* File: ssrx_master_model.sv */
/*
 * Model of the external synchronous master that drives the link pins.
 * Assumes the receiver samples data on the rising edge of the shift clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ssrx_master_model (
    input wire logic clk_i,
    output logic shift_clk_o,
    output logic data_o
);
    // Clock stands low between frames
    initial begin
        shift_clk_o = 1'b0;
        data_o = 1'b0;
    end
    // One frame; pins move just after a system clock edge, data with the fall
    task automatic send_word(input logic [8:0] word, input int nbits, input int half_cycles);
        for (int i = 0; i < nbits; i++) begin
            data_o <= word[i];
            repeat (half_cycles) @(posedge clk_i);
            shift_clk_o <= 1'b1;
            repeat (half_cycles) @(posedge clk_i);
            shift_clk_o <= 1'b0;
        end
        // Released line shows no stale bit
        data_o <= ~word[nbits - 1];
    endtask
endmodule
`default_nettype wire

/* File: tb_sync_slave_serial_receiver.sv */
/*
 * Self-checking bench for the synchronous slave receiver.
 * Assumes the master model drives the link and the bench is the bus master.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_sync_slave_serial_receiver;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic sleep = 1'b0;
    logic [7:0] rdata;
    logic waitreq;
    logic shift_clk;
    logic data_line;
    logic irq;
    logic wake;
    logic branch;
    logic [12:0] vec;
    logic [7:0] got;
    int err_total = 0;
    int total_checks = 0;
    // 100 MHz system clock
    always #5 mclk_i = ~mclk_i;
    ssrx_top u_dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .shift_clk_pin_i(shift_clk), .data_pin_i(data_line),
        .core_sleep_i(sleep), .irq_o(irq), .wake_o(wake), .branch_to_vector_o(branch),
        .vector_addr_o(vec)
    );
    ssrx_master_model u_master (.clk_i(mclk_i), .shift_clk_o(shift_clk), .data_o(data_line));
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        // No local limit: a slave that never answers is left to the watchdog
        do begin
            @(posedge mclk_i);
        end while (waitreq !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(what, {8'h00, got}, {8'h00, exp});
    endtask
    // One frame, then let the result land; half period counted in 10 ns cycles
    task automatic tx(input logic [8:0] w, input int nbits, input int half_ns);
        u_master.send_word(w, nbits, half_ns / 10);
        repeat (6) @(posedge mclk_i);
    endtask
    task automatic t_regs();
        logic [7:0] idx [9] = '{8'h0B, 8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h55};
        logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) rchk("reset value", idx[i], rv[i]);
        wreg(8'h0B, 8'hFF);
        rchk("global bits", 8'h0B, 8'hC0);
        wreg(8'h0B, 8'h00);
        wreg(8'h1A, 8'h77);
        wreg(8'h55, 8'h77);
        rchk("holding ro", 8'h1A, 8'h00);
        rchk("unmapped", 8'h55, 8'h00);
        wreg(8'h19, 8'hA5);
        rchk("transmit holding", 8'h19, 8'hA5);
        wreg(8'h99, 8'h3C);
        rchk("baud divisor", 8'h99, 8'h3C);
        wreg(8'h98, 8'hFF);
        rchk("transmit status", 8'h98, 8'hF7);
        wreg(8'h98, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_rx8();
        wreg(8'h98, 8'h10);
        wreg(8'h8C, 8'h20);
        wreg(8'h18, 8'hA0);
        tx(9'h0A5, 8, 80);
        rchk("single only", 8'h0C, 8'h00);
        check("irq idle", irq, 1'b0);
        wreg(8'h18, 8'hB0);
        tx(9'h05A, 8, 80);
        rchk("flag", 8'h0C, 8'h20);
        check("irq", irq, 1'b1);
        rchk("holding", 8'h1A, 8'h5A);
        wreg(8'h0C, 8'h20);
        check("irq clear", irq, 1'b0);
        wreg(8'h8C, 8'h00);
        tx(9'h081, 8, 80);
        check("irq masked", irq, 1'b0);
        rchk("holding 2", 8'h1A, 8'h81);
        wreg(8'h0C, 8'h20);
        $display("test rx8 done");
    endtask
    task automatic t_nine();
        wreg(8'h18, 8'hD0);
        tx(9'h1C3, 9, 80);
        rchk("ninth bit", 8'h18, 8'hD1);
        rchk("nine data", 8'h1A, 8'hC3);
        wreg(8'h0C, 8'h20);
        $display("test nine done");
    endtask
    task automatic t_overrun();
        wreg(8'h18, 8'h90);
        tx(9'h011, 8, 80);
        tx(9'h022, 8, 80);
        rchk("overrun", 8'h18, 8'h92);
        tx(9'h033, 8, 80);
        rchk("kept word", 8'h1A, 8'h11);
        wreg(8'h18, 8'h80);
        rchk("err cleared", 8'h18, 8'h80);
        wreg(8'h0C, 8'h20);
        $display("test overrun done");
    endtask
    task automatic t_sleep();
        sleep <= 1'b1;
        wreg(8'h0B, 8'h40);
        wreg(8'h8C, 8'h20);
        wreg(8'h18, 8'h90);
        tx(9'h03C, 8, 80);
        check("wake", wake, 1'b1);
        check("no branch", {branch, vec}, 14'h0000);
        wreg(8'h0B, 8'hC0);
        check("branch", {branch, vec}, 14'h2004);
        wreg(8'h8C, 8'h00);
        check("wake masked", wake, 1'b0);
        wreg(8'h0C, 8'h20);
        sleep <= 1'b0;
        wreg(8'h0B, 8'h00);
        $display("test sleep done");
    endtask
    task automatic t_master();
        wreg(8'h98, 8'h90);
        tx(9'h0E7, 8, 80);
        rchk("master ignored", 8'h0C, 8'h00);
        wreg(8'h98, 8'h10);
        wreg(8'h18, 8'h10);
        tx(9'h0E7, 8, 80);
        rchk("port disabled", 8'h0C, 8'h00);
        wreg(8'h98, 8'h00);
        wreg(8'h18, 8'h90);
        tx(9'h0E7, 8, 80);
        rchk("async mode", 8'h0C, 8'h00);
        wreg(8'h18, 8'h00);
        $display("test master done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after 20 cycles of reset
    initial begin
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        t_regs();
        t_rx8();
        t_nine();
        t_overrun();
        t_sleep();
        t_master();
        finish_test();
    end
    // Watchdog well beyond the expected run of about 17 us
    initial begin
        #300us;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
